// >>> rtl/pic_pkg.sv
// Constants and types of the parallel core interrupt controller
package pic_pkg;

  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned IDX_W       = 5;
  localparam int unsigned PEER_N      = 4;

  // APB byte offsets
  localparam logic [11:0] OFF_MASK    = 12'h000;
  localparam logic [11:0] OFF_FLAGS   = 12'h004;
  localparam logic [11:0] OFF_STAT    = 12'h008;

  // Enable mask and program counter bits
  localparam int unsigned MASK_WMODE  = 0;
  localparam int unsigned PC_LOOP     = 0;
  localparam int unsigned PC_GLOBAL   = 1;

  // Pending flag positions of the nine implemented sources
  localparam int unsigned FLG_DONE    = 9;
  localparam int unsigned FLG_FAULT   = 10;
  localparam int unsigned FLG_OVERRUN = 11;
  localparam int unsigned FLG_TASK    = 14;
  localparam int unsigned FLG_PEER0   = 24;
  localparam int unsigned FLG_MASTER  = 31;

  // Status register fields
  localparam int unsigned STAT_LOOP   = 0;
  localparam int unsigned STAT_GLOBAL = 1;
  localparam int unsigned STAT_BUSY   = 2;
  localparam int unsigned STAT_PEND   = 3;
  localparam int unsigned STAT_IDX    = 8;

  // Flag bits 1..31 hold sources, bit 0 has none
  localparam logic [31:0] FLAG_IMPL   = 32'hFFFF_FFFE;
  localparam logic [31:0] MASK_RST    = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST   = 32'h0000_0000;

  typedef enum logic [2:0] {
    PIC_IDLE  = 3'b001,
    PIC_TAKE  = 3'b010,
    PIC_ENTRY = 3'b100
  } pic_state_t;

  typedef struct packed {
    logic g;
    logic l;
  } pic_pcbits_t;

endpackage : pic_pkg

// >>> rtl/pic_prio.sv
// Fixed priority picker, lowest set bit wins
`timescale 1ns/1ps
module pic_prio (
  input  wire logic [31:0] req,
  output logic             any,
  output logic [4:0]       idx
);

  always_comb begin
    any = |req;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (req[i]) begin
        idx = 5'(i);
      end
    end
  end

endmodule : pic_prio

// >>> rtl/pic_gctl.sv
// Global enable and loop inhibit bits of the program counter
`timescale 1ns/1ps
module pic_gctl (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       eint,
  input  wire logic       dint,
  input  wire logic       pc_load,
  input  wire logic       pc_load_unscaled,
  input  wire logic       pc_load_addr_b1,
  input  wire logic       pc_load_g,
  input  wire logic       vec_load,
  input  wire logic [1:0] vec_lsb,
  output logic            glob_en,
  output logic            loop_inh
);

  pic_pkg::pic_pcbits_t cur_reg;
  pic_pkg::pic_pcbits_t cur_next;

  always_comb begin
    cur_next = cur_reg;
    if (vec_load) begin
      cur_next.g = vec_lsb[pic_pkg::PC_GLOBAL];
      cur_next.l = vec_lsb[pic_pkg::PC_LOOP];
    end else if (dint) begin
      cur_next.g = 1'b0;
    end else if (eint) begin
      cur_next.g = 1'b1;
    end else if (pc_load && pc_load_unscaled && pc_load_addr_b1) begin
      cur_next.g = pc_load_g;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign glob_en  = cur_reg.g;
  assign loop_inh = cur_reg.l;

  a_entry_copy: assert property (@(posedge pclk) disable iff (!presetn)
    vec_load |=> (glob_en == $past(vec_lsb[1])) && (loop_inh == $past(vec_lsb[0])))
    else $error("vector bits not copied on entry");
  a_eint_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (eint && !dint && !vec_load) |=> glob_en)
    else $error("enable-on did not set global enable");
  a_load_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!eint && !dint && !vec_load && !(pc_load && pc_load_unscaled && pc_load_addr_b1))
      |=> $stable(glob_en))
    else $error("global enable changed without cause");

endmodule : pic_gctl

// >>> rtl/pic_irq_ctrl.sv
// Interrupt controller of one parallel core with APB register access
//
// Functional notes
// - Room for 31 source flags; nine real sources drive flag bits.
// - Disabled sources still set their flags; no service, software may poll.
// - Global enable is program counter bit 1; when 0 nothing is serviced.
// - With global enable on, a source is eligible when its mask bit is 1.
// - Enable-on sets the global enable, enable-off clears it.
// - Data unit branches and register moves into pc leave global enable.
// - Memory load into pc changes it only for unscaled immediate, bit 1 set.
// - Mask register holds one enable bit per source.
// - Mask bit 0 is write mode; at 0 written ones clear flags.
// - With write mode 1, written ones set flags, zeros keep them.
// - Flags latch requests and hold until software clears them.
// - Lowest flag bit has highest priority, falling toward the left.
// - Reserved flag bits act like sources; software clears them after reset.
// - Task switch flag set by the master core command.
// - Overrun flag set when a transfer is requested while one is queued.
// - Fault flag set when the transfer engine fails this core's transfer.
// - Done flag set at list end or on a notifying listed transfer.
// - Master note flag set by a master core message.
// - Peer note flags 0 to 3 set by peer messages, self included.
// - A set in the same cycle as a software clear leaves the flag 1.
// - Pending enabled highest interrupt is accepted on the following cycle.
// - Software must initialise mask and flags before enabling globally.
// - On entry, vector bits 1:0 load global enable and loop inhibit.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module pic_irq_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        task_cmd,
  input  wire logic        xfer_req_wr,
  input  wire logic        xfer_queued,
  input  wire logic        xfer_fault,
  input  wire logic        xfer_done,
  input  wire logic        master_note,
  input  wire logic [3:0]  peer_note,
  input  wire logic        eint,
  input  wire logic        dint,
  input  wire logic        pc_load,
  input  wire logic        pc_load_unscaled,
  input  wire logic        pc_load_addr_b1,
  input  wire logic        pc_load_g,
  input  wire logic        vec_load,
  input  wire logic [1:0]  vec_lsb,
  output logic             irq_take,
  output logic [4:0]       irq_index,
  output logic             irq_pending,
  output logic             glob_en,
  output logic             loop_inh
);

  typedef struct packed {
    logic [31:0]         mask;
    logic [31:0]         flags;
    pic_pkg::pic_state_t st;
    logic [4:0]          idx;
    logic [31:0]         rdata;
    logic                err;
  } pic_regs_t;

  pic_regs_t   cr_reg;
  pic_regs_t   cr_next;
  logic [31:0] src_set;
  logic [31:0] flags_sw;
  logic [31:0] en_pend;
  logic        pick_any;
  logic [4:0]  pick_idx;
  logic        setup;
  logic        wr;
  logic        hit_mask;
  logic        hit_flags;
  logic        hit_stat;

  pic_gctl u_gctl (
    .pclk             (pclk),
    .presetn          (presetn),
    .eint             (eint),
    .dint             (dint),
    .pc_load          (pc_load),
    .pc_load_unscaled (pc_load_unscaled),
    .pc_load_addr_b1  (pc_load_addr_b1),
    .pc_load_g        (pc_load_g),
    .vec_load         (vec_load),
    .vec_lsb          (vec_lsb),
    .glob_en          (glob_en),
    .loop_inh         (loop_inh)
  );

  // Enabled and pending, bit 0 excluded since it is the write mode bit
  assign en_pend = cr_reg.flags & cr_reg.mask & pic_pkg::FLAG_IMPL;

  pic_prio u_prio (
    .req (en_pend),
    .any (pick_any),
    .idx (pick_idx)
  );

  assign setup     = psel && !penable;
  assign wr        = psel && penable && pwrite;
  assign hit_mask  = (paddr == pic_pkg::OFF_MASK);
  assign hit_flags = (paddr == pic_pkg::OFF_FLAGS);
  assign hit_stat  = (paddr == pic_pkg::OFF_STAT);

  // Hardware set requests, one per implemented source
  always_comb begin
    src_set                       = 32'h0000_0000;
    src_set[pic_pkg::FLG_TASK]    = task_cmd;
    src_set[pic_pkg::FLG_OVERRUN] = xfer_req_wr && xfer_queued;
    src_set[pic_pkg::FLG_FAULT]   = xfer_fault;
    src_set[pic_pkg::FLG_DONE]    = xfer_done;
    src_set[pic_pkg::FLG_MASTER]  = master_note;
    for (int p = 0; p < 4; p++) begin
      src_set[pic_pkg::FLG_PEER0 + p] = peer_note[p];
    end
  end

  always_comb begin
    cr_next  = cr_reg;
    flags_sw = cr_reg.flags;
    if (wr && hit_mask) begin
      cr_next.mask = pwdata;
    end
    if (wr && hit_flags) begin
      if (cr_reg.mask[pic_pkg::MASK_WMODE]) begin
        flags_sw = cr_reg.flags | pwdata;
      end else begin
        flags_sw = cr_reg.flags & ~pwdata;
      end
    end
    // Sets win over a coincident clear, enables play no part
    cr_next.flags = (flags_sw | src_set) & pic_pkg::FLAG_IMPL;
    if (setup) begin
      cr_next.err   = !(hit_mask || hit_flags || hit_stat);
      cr_next.rdata = 32'h0000_0000;
      if (hit_mask) begin
        cr_next.rdata = cr_reg.mask;
      end else if (hit_flags) begin
        cr_next.rdata = cr_reg.flags;
      end else if (hit_stat) begin
        cr_next.rdata[pic_pkg::STAT_LOOP]   = loop_inh;
        cr_next.rdata[pic_pkg::STAT_GLOBAL] = glob_en;
        cr_next.rdata[pic_pkg::STAT_BUSY]   = (cr_reg.st != pic_pkg::PIC_IDLE);
        cr_next.rdata[pic_pkg::STAT_PEND]   = pick_any;
        cr_next.rdata[pic_pkg::STAT_IDX +: 5] = pick_idx;
      end
    end
    case (cr_reg.st)
      pic_pkg::PIC_IDLE: begin
        // Accept the winner one cycle after it is seen
        if (glob_en && pick_any) begin
          cr_next.st  = pic_pkg::PIC_TAKE;
          cr_next.idx = pick_idx;
        end
      end
      pic_pkg::PIC_TAKE: begin
        cr_next.st = vec_load ? pic_pkg::PIC_IDLE : pic_pkg::PIC_ENTRY;
      end
      pic_pkg::PIC_ENTRY: begin
        // Hold off further accepts until the vector bits are loaded
        if (vec_load) begin
          cr_next.st = pic_pkg::PIC_IDLE;
        end
      end
      default: begin
        cr_next.st = pic_pkg::PIC_IDLE;
      end
    endcase
  end

  // Reset values are defined though software must still initialise both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cr_reg.mask  <= pic_pkg::MASK_RST;
      cr_reg.flags <= pic_pkg::FLAGS_RST;
      cr_reg.st    <= pic_pkg::PIC_IDLE;
      cr_reg.idx   <= 5'h00;
      cr_reg.rdata <= 32'h0000_0000;
      cr_reg.err   <= 1'b0;
    end else begin
      cr_reg <= cr_next;
    end
  end

  assign prdata      = cr_reg.rdata;
  assign pslverr     = cr_reg.err;
  assign pready      = 1'b1;
  assign irq_take    = (cr_reg.st == pic_pkg::PIC_TAKE);
  assign irq_index   = cr_reg.idx;
  assign irq_pending = pick_any;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_set_wins_clear: assert property (
    task_cmd |=> cr_reg.flags[14])
    else $error("task flag lost against a clear");
  a_overrun_set: assert property (
    (xfer_req_wr && xfer_queued) |=> cr_reg.flags[11])
    else $error("overrun flag not set");
  a_overrun_quiet: assert property (
    (!xfer_req_wr && !(wr && hit_flags) && !cr_reg.flags[11]) |=> !cr_reg.flags[11])
    else $error("overrun flag set without cause");
  a_flag_hold: assert property (
    (!(wr && hit_flags) && src_set == 32'h0) |=> $stable(cr_reg.flags))
    else $error("flags changed without write or request");
  a_clear_mode: assert property (
    (wr && hit_flags && !cr_reg.mask[0] && src_set == 32'h0)
      |=> cr_reg.flags == ($past(cr_reg.flags) & ~$past(pwdata) & 32'hFFFF_FFFE))
    else $error("clear mode write wrong");
  a_set_mode: assert property (
    (wr && hit_flags && cr_reg.mask[0])
      |=> cr_reg.flags == (($past(cr_reg.flags) | $past(pwdata)) & 32'hFFFF_FFFE))
    else $error("set mode write wrong");
  a_global_gate: assert property (
    $rose(irq_take) |-> $past(glob_en))
    else $error("accept while globally disabled");
  a_take_next: assert property (
    (cr_reg.st == pic_pkg::PIC_IDLE && glob_en && pick_any) |=> irq_take ##0
      irq_index == $past(pick_idx))
    else $error("pending interrupt not accepted next cycle");
  a_prio_lowest: assert property (
    pick_any |-> en_pend[pick_idx] && ((en_pend & ((32'h1 << pick_idx) - 32'h1)) == 32'h0))
    else $error("lower bit pending but not chosen");
  a_single_take: assert property (
    (irq_take && !vec_load) |=> !irq_take [*2])
    else $error("second accept before vector entry");
  a_disabled_sets: assert property (
    (master_note && !cr_reg.mask[pic_pkg::FLG_MASTER])
      |=> cr_reg.flags[pic_pkg::FLG_MASTER]
        && !(irq_take && (irq_index == 5'(pic_pkg::FLG_MASTER))))
    else $error("disabled source flag or service wrong");
  a_apb_err: assert property (
    (setup && !(hit_mask || hit_flags || hit_stat)) |=> pslverr)
    else $error("unmapped access not flagged");

  // Source requests land in their flags
  a_fault_set: assert property (
    xfer_fault |=> cr_reg.flags[pic_pkg::FLG_FAULT])
    else $error("fault flag not set");
  a_done_set: assert property (
    xfer_done |=> cr_reg.flags[pic_pkg::FLG_DONE])
    else $error("done flag not set");
  a_master_set: assert property (
    master_note |=> cr_reg.flags[pic_pkg::FLG_MASTER])
    else $error("master note flag not set");
  for (genvar p = 0; p < 4; p++) begin : g_peer_chk
    a_peer_set: assert property (
      peer_note[p] |=> cr_reg.flags[pic_pkg::FLG_PEER0 + p])
      else $error("peer note flag not set");
  end
  a_overrun_needs: assert property (
    (xfer_req_wr && !xfer_queued && !(wr && hit_flags)
      && !cr_reg.flags[pic_pkg::FLG_OVERRUN]) |=> !cr_reg.flags[pic_pkg::FLG_OVERRUN])
    else $error("overrun flag set without a queued transfer");
  a_reserved_set: assert property (
    (wr && hit_flags && cr_reg.mask[pic_pkg::MASK_WMODE] && pwdata[28])
      |=> cr_reg.flags[28])
    else $error("reserved flag not settable");

  // Software access to mask, flags and status
  a_mask_write: assert property (
    (wr && hit_mask) |=> (cr_reg.mask == $past(pwdata)))
    else $error("mask write lost");
  a_mask_hold: assert property (
    !(wr && hit_mask) |=> $stable(cr_reg.mask))
    else $error("mask changed without write");
  a_no_hw_clear: assert property (
    !(wr && hit_flags)
      |=> ((cr_reg.flags & $past(cr_reg.flags)) == $past(cr_reg.flags)))
    else $error("flag cleared by hardware");
  a_zero_write: assert property (
    (wr && hit_flags && (pwdata == 32'h0000_0000))
      |=> (cr_reg.flags == ($past(cr_reg.flags) | $past(src_set))))
    else $error("zero write changed flags");
  a_flags_read: assert property (
    (setup && hit_flags) |=> (prdata == $past(cr_reg.flags)))
    else $error("flag read data wrong");
  a_mask_read: assert property (
    (setup && hit_mask) |=> (prdata == $past(cr_reg.mask)))
    else $error("mask read data wrong");
  a_stat_glob: assert property (
    (setup && hit_stat) |=> (prdata[pic_pkg::STAT_GLOBAL] == $past(glob_en)))
    else $error("status global bit wrong");
  a_stat_idx: assert property (
    (setup && hit_stat) |=> (prdata[pic_pkg::STAT_IDX +: 5] == $past(pick_idx)))
    else $error("status index wrong");

  // Acceptance and priority
  a_take_source: assert property (
    pick_any |-> (cr_reg.mask[pick_idx] && cr_reg.flags[pick_idx]))
    else $error("winner not enabled and pending");
  a_no_bit0: assert property (
    pick_any |-> (pick_idx != 5'h00))
    else $error("write mode bit taken as source");
  a_gate_off: assert property (
    (cr_reg.st == pic_pkg::PIC_IDLE && !glob_en) |=> !irq_take)
    else $error("accept with global enable off");
  a_gate_mask: assert property (
    (cr_reg.st == pic_pkg::PIC_IDLE && !pick_any) |=> !irq_take)
    else $error("accept with nothing enabled");
  a_pend_level: assert property (
    (cr_reg.flags[pic_pkg::FLG_TASK] && cr_reg.mask[pic_pkg::FLG_TASK]) |-> irq_pending)
    else $error("enabled task flag not pending");
  a_busy_hold: assert property (
    (cr_reg.st == pic_pkg::PIC_ENTRY && !vec_load)
      |=> (cr_reg.st == pic_pkg::PIC_ENTRY))
    else $error("entry left before vector load");
  a_entry_leave: assert property (
    (cr_reg.st == pic_pkg::PIC_ENTRY && vec_load) |=> (cr_reg.st == pic_pkg::PIC_IDLE))
    else $error("entry not left on vector load");
  a_index_hold: assert property (
    irq_take |=> $stable(irq_index))
    else $error("index moved after accept");

  // Global enable control
  a_dint_clears: assert property (
    (dint && !vec_load) |=> !glob_en)
    else $error("enable-off did not clear global enable");
  a_load_sets: assert property (
    (pc_load && pc_load_unscaled && pc_load_addr_b1 && !eint && !dint && !vec_load)
      |=> (glob_en == $past(pc_load_g)))
    else $error("qualified pc load did not set global enable");
  a_load_ignored: assert property (
    (pc_load && !pc_load_unscaled && !eint && !dint && !vec_load)
      |=> $stable(glob_en))
    else $error("unqualified pc load changed global enable");

  c_take:      cover property (irq_take ##1 vec_load);
  c_set_clear: cover property (wr && hit_flags && !cr_reg.mask[0] && src_set != 32'h0);
  c_restore:   cover property (wr && hit_flags && cr_reg.mask[0]);
  c_two_pend:  cover property (pick_any && ($countones(en_pend) > 1));
  c_reserved:  cover property (en_pend[28]);

endmodule : pic_irq_ctrl

// >>> bench/pic_src_model.sv
// Request lines of the master core, peer cores and transfer engine
`timescale 1ns/1ps
module pic_src_model (
  input  wire logic       go,
  input  wire logic [3:0] ev,
  output logic            task_cmd,
  output logic            xfer_req_wr,
  output logic            xfer_queued,
  output logic            xfer_fault,
  output logic            xfer_done,
  output logic            master_note,
  output logic [3:0]      peer_note
);
  // One request per cycle of go, all lines idle low otherwise
  always_comb begin
    {task_cmd, xfer_req_wr, xfer_queued, xfer_fault, xfer_done, master_note} = '0;
    peer_note = 4'h0;
    if (go) begin
      case (ev)
        4'h0: xfer_done = 1'b1;
        4'h1: xfer_fault = 1'b1;
        4'h2: {xfer_req_wr, xfer_queued} = 2'b11;
        4'h3: task_cmd = 1'b1;
        4'h4: master_note = 1'b1;
        4'h5, 4'h6, 4'h7, 4'h8: peer_note = 4'h1 << (ev - 4'h5);
        4'h9: xfer_req_wr = 1'b1;
        default: master_note = 1'b0;
      endcase
    end
  end
endmodule : pic_src_model

// >>> bench/pic_irq_ctrl_tb_top.sv
// Self-checking bench of the parallel core interrupt controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module pic_irq_ctrl_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  ev, peer_note;
  logic [8:0]  cb;
  logic [4:0]  irq_index;
  logic        task_cmd, xfer_req_wr, xfer_queued, xfer_fault, xfer_done, master_note;
  logic        irq_take, irq_pending, glob_en, loop_inh;
  int          seed, mismatches, total_checks;
  logic [31:0] cm[3] = '{32'hFFFF_FFFF, 32'h8000_0000, 32'h0};
  logic [31:0] cf[3] = '{32'h0000_0002, 32'hFFFF_FFFE, 32'hFFFF_FFFF};
  logic [8:0]  cv[5] = '{9'h058, 9'h078, 9'h080, 9'h005, 9'h100};
  logic [1:0]  gl[5] = '{2'b00, 2'b10, 2'b00, 2'b01, 2'b11};

  pic_irq_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .task_cmd(task_cmd), .xfer_req_wr(xfer_req_wr),
    .xfer_queued(xfer_queued), .xfer_fault(xfer_fault), .xfer_done(xfer_done),
    .master_note(master_note), .peer_note(peer_note), .eint(cb[8]), .dint(cb[7]),
    .pc_load(cb[6]), .pc_load_unscaled(cb[5]), .pc_load_addr_b1(cb[4]),
    .pc_load_g(cb[3]), .vec_load(cb[2]), .vec_lsb(cb[1:0]), .irq_take(irq_take),
    .irq_index(irq_index), .irq_pending(irq_pending), .glob_en(glob_en),
    .loop_inh(loop_inh));
  pic_src_model SRC (.go(go), .ev(ev), .task_cmd(task_cmd), .xfer_req_wr(xfer_req_wr),
    .xfer_queued(xfer_queued), .xfer_fault(xfer_fault), .xfer_done(xfer_done),
    .master_note(master_note), .peer_note(peer_note));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rdat)
  endtask : rd

  task automatic src(input int e);
    @(posedge pclk);
    {go, ev} <= {1'b1, 4'(e)};
    @(posedge pclk);
    go <= 1'b0;
  endtask : src

  task automatic ctl(input logic [8:0] v);
    @(posedge pclk);
    cb <= v;
    @(posedge pclk);
    cb <= 9'h000;
  endtask : ctl

  function automatic logic [31:0] ebit(input int e);
    case (e)
      0: ebit = 32'h1 << pic_pkg::FLG_DONE;
      1: ebit = 32'h1 << pic_pkg::FLG_FAULT;
      2: ebit = 32'h1 << pic_pkg::FLG_OVERRUN;
      3: ebit = 32'h1 << pic_pkg::FLG_TASK;
      4: ebit = 32'h1 << pic_pkg::FLG_MASTER;
      9: ebit = 32'h0;
      default: ebit = 32'h1 << (pic_pkg::FLG_PEER0 + e - 5);
    endcase
  endfunction : ebit

  function automatic logic [4:0] low(input logic [31:0] v);
    low = 5'h00;
    for (int i = 31; i >= 0; i--) if (v[i]) low = 5'(i);
  endfunction : low

  task automatic acc(input logic [31:0] m, input logic [31:0] f);
    logic [31:0] p;
    p = m & f & pic_pkg::FLAG_IMPL;
    wr(pic_pkg::OFF_MASK, m | 32'h1);
    wr(pic_pkg::OFF_FLAGS, f);
    repeat (3) @(negedge pclk);
    `CHK("no_take", 1'b0, irq_take)
    `CHK("pend", |p, irq_pending)
    ctl(9'h100);
    repeat (2) @(negedge pclk);
    `CHK("take", p != 0, irq_take)
    if (p != 0) `CHK("index", low(p), irq_index)
    ctl(9'h004);
    @(negedge pclk);
    `CHK("g_vec", 2'b00, {glob_en, loop_inh})
    rd(pic_pkg::OFF_FLAGS, f & pic_pkg::FLAG_IMPL, "flags");
    wr(pic_pkg::OFF_MASK, m & ~32'h1);
    wr(pic_pkg::OFF_FLAGS, 32'hFFFF_FFFF);
    rd(pic_pkg::OFF_FLAGS, 32'h0, "clr");
  endtask : acc

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    close_out();
  end

  initial begin
    seed = 32'h27D8;
    {presetn, psel, penable, pwrite, paddr, pwdata, go, ev, cb} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(pic_pkg::OFF_MASK, 32'h0, "mask_rst");
    rd(pic_pkg::OFF_STAT, 32'h0, "stat_rst");
    wr(12'h00C, 32'hFFFF_FFFF);
    `CHK("slverr", 1'b1, rerr)
    rd(pic_pkg::OFF_MASK, 32'h0, "mask_kept");
    $display("test reset done");
    for (int e = 0; e < 10; e++) begin
      src(e);
      rd(pic_pkg::OFF_FLAGS, ebit(e), "src_flag");
      wr(pic_pkg::OFF_FLAGS, 32'hFFFF_FFFF);
      rd(pic_pkg::OFF_FLAGS, 32'h0, "src_clr");
    end
    $display("test sources done");
    src(4);
    fork
      wr(pic_pkg::OFF_FLAGS, 32'h8000_0000);
      begin
        repeat (2) @(posedge pclk);
        {go, ev} <= {1'b1, 4'h4};
        @(posedge pclk);
        go <= 1'b0;
      end
    join
    rd(pic_pkg::OFF_FLAGS, 32'h8000_0000, "set_wins");
    wr(pic_pkg::OFF_FLAGS, 32'h8000_0000);
    $display("test set_wins done");
    for (int i = 0; i < 3; i++) acc(cm[i], cf[i]);
    for (int i = 0; i < 8; i++) acc($random(seed), $random(seed));
    $display("test accept done");
    for (int i = 0; i < 5; i++) begin
      ctl(cv[i]);
      @(negedge pclk);
      `CHK("gl", gl[i], {glob_en, loop_inh})
    end
    ctl(9'h080);
    wr(pic_pkg::OFF_STAT, 32'hFFFF_FFFF);
    rd(pic_pkg::OFF_STAT, 32'h1, "stat");
    $display("test global done");
    close_out();
  end
endmodule : pic_irq_ctrl_tb_top
